// [verilog/logger_ctrl.v]
// data logger control and card store status, with a classic wishbone slave
// Summary of operation
// [R1] configured flag follows valid downloaded parameters
// [R2] record-run set and cleared by software only
// [R3] software loads store word with the key
// [R4] limit reached or count met starts save
// [R5] trigger rise with key starts card write
// [R6] record count is 32 bits, +1 per record while record-run is set, held at the limit unless cyclic
// [R7] store word reads zero after store finishes
// [R8] card-present flag follows card detect
// [R9] storing flag high for whole card write
// [R10] card-error flag set on failed card operation
// [R11] last card error code latched, read-only
// [R12] limit flag at count or in cyclic mode
// [R13] software keeps interrupts quiet during store
// [R14] log file stamped with date and time
// [R15] read-only items ignore writes, writable accept
// [R16] trigger rise without key does nothing
// [R17] busy clears with store word zeroing
`timescale 1ns/1ps
`default_nettype none
`include "logger_regs.vh"

module logger_ctrl (
  // clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [31:0] dat_i,
  input  wire [3:0]  sel_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // logger engine
  input  wire        params_valid,
  input  wire        record_taken,
  // memory card
  input  wire        card_detect,
  input  wire        card_done,
  input  wire        card_fail,
  input  wire [15:0] card_fail_code,
  output wire        card_store_start,
  // real time clock: year, month, day, hour, minute, second
  input  wire [15:0] rtc_year,
  input  wire [7:0]  rtc_month,
  input  wire [7:0]  rtc_day,
  input  wire [7:0]  rtc_hour,
  input  wire [7:0]  rtc_minute,
  input  wire [7:0]  rtc_second,
  output reg  [55:0] file_stamp_q,
  // interrupt
  output wire        irq
);

  reg [`CT_WIDTH-1:0]  control_q;
  reg [15:0]           store_word_q;
  reg [15:0]           err_code_q;
  reg                  card_error_q;
  reg [31:0]           rec_count_q;
  reg [31:0]           rec_limit_q;
  reg [`IRQ_WIDTH-1:0] irq_status_q;
  reg [`IRQ_WIDTH-1:0] irq_mask_q;
  reg                  trig_prev_q;
  reg                  limit_prev_q;
  reg                  card_prev_q;

  wire                  busy_q;
  wire                  store_finish;
  wire                  store_failed;
  wire                  access;
  wire                  wr;
  wire                  trig_rise;
  wire                  limit_rise;
  wire                  key_ok;
  wire                  store_go;
  wire                  count_met;
  wire                  limit_now;
  wire                  record_ok;
  wire [4:0]            status_word;
  wire [`IRQ_WIDTH-1:0] irq_events;
  wire [31:0]           ctrl_wr;
  wire [31:0]           word_wr;
  wire [31:0]           limit_wr;
  wire [31:0]           mask_wr;
  wire                  sel_control;
  wire                  sel_word;
  wire                  sel_limit;
  wire                  sel_mask;
  wire                  sel_irq;
  wire                  store_ok;
  wire                  card_change;
  wire [`IRQ_WIDTH-1:0] irq_clr;
  reg  [31:0]           read_word;

  // byte-lane merge of a write into the old word
  function [31:0] lane_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  lanes;
    integer      i;
    begin
      lane_merge = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (lanes[i]) begin
          lane_merge[i*8 +: 8] = new_val[i*8 +: 8];
        end
      end
    end
  endfunction

  // bus decode: one answer per request, ack drops the cycle after
  assign access = cyc_i & stb_i & ~ack_o;
  assign wr     = access & we_i;

  assign ctrl_wr  = lane_merge({29'h0000_0000, control_q}, dat_i, sel_i);
  assign word_wr  = lane_merge({16'h0000, store_word_q}, dat_i, sel_i);
  assign limit_wr = lane_merge(rec_limit_q, dat_i, sel_i);
  // the mask merges into its own old value, so a write without lane 0 keeps it
  assign mask_wr  = lane_merge({28'h000_0000, irq_mask_q}, dat_i, sel_i);

  // one select per writable register, decoded once for every process
  assign sel_control = wr & (adr_i == `OFF_CONTROL);
  assign sel_word    = wr & (adr_i == `OFF_STORE_WORD);
  assign sel_limit   = wr & (adr_i == `OFF_REC_LIMIT);
  assign sel_mask    = wr & (adr_i == `OFF_IRQ_MASK);
  assign sel_irq     = wr & (adr_i == `OFF_IRQ_STATUS);

  // count limit: zero limit means no limit configured
  assign count_met = (rec_limit_q != 32'h0000_0000) & (rec_count_q >= rec_limit_q);
  assign limit_now = count_met | control_q[`CT_CYCLIC]; // R12

  // records stop at the limit unless recording wraps round
  assign record_ok = record_taken & control_q[`CT_RECORD_RUN] & params_valid
                     & (~count_met | control_q[`CT_CYCLIC]);

  // a store only starts while the key is loaded and nothing is in flight
  assign trig_rise  = control_q[`CT_STORE_TRIG] & ~trig_prev_q;
  assign limit_rise = limit_now & ~limit_prev_q;
  assign key_ok     = (store_word_q == `STORE_KEY); // R3
  assign store_go   = key_ok & ~busy_q & (trig_rise | limit_rise); // R4 R5 R16

  assign status_word = {params_valid,            // R1
                        limit_now,               // R12
                        card_error_q,            // R10
                        busy_q,                  // R9
                        card_detect};            // R8

  assign store_ok    = store_finish & ~store_failed;
  assign card_change = card_detect ^ card_prev_q;

  // write-one clear uses lane 0 only
  assign irq_clr = dat_i[`IRQ_WIDTH-1:0] & {`IRQ_WIDTH{sel_i[0] & sel_irq}};

  assign irq_events = {card_change,
                       limit_rise,
                       store_failed,
                       store_finish};

  assign irq = |(irq_status_q & irq_mask_q);

  store_sequencer u_seq (
    .clock     (clock),
    .rst_n     (rst_n),
    .go        (store_go),
    .card_done (card_done),
    .card_fail (card_fail),
    .busy_q    (busy_q),
    .start_q   (card_store_start),
    .finish    (store_finish),
    .failed    (store_failed)
  );

  // read multiplexer: unmapped offsets read zero
  always @* begin
    read_word = 32'h0000_0000;
    case (adr_i)
      `OFF_STATUS:     read_word = {27'h000_0000, status_word};
      `OFF_CONTROL:    read_word = {29'h0000_0000, control_q};
      `OFF_STORE_WORD: read_word = {16'h0000, store_word_q};
      `OFF_ERR_CODE:   read_word = {16'h0000, err_code_q}; // R11
      `OFF_REC_COUNT:  read_word = rec_count_q;
      `OFF_REC_LIMIT:  read_word = rec_limit_q;
      `OFF_IRQ_STATUS: read_word = {28'h000_0000, irq_status_q};
      `OFF_IRQ_MASK:   read_word = {28'h000_0000, irq_mask_q};
      default:         read_word = 32'h0000_0000;
    endcase
  end

  // wishbone answer and read data; data only moves on a read, so it stands
  always @(posedge clock) begin
    if (!rst_n) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= access;
      if (access & ~we_i) begin
        dat_o <= read_word;
      end
    end
  end

  // writable control bits: the device never clears them itself
  always @(posedge clock) begin
    if (!rst_n) begin
      control_q <= `RST_CONTROL;
    end else if (sel_control) begin
      control_q <= ctrl_wr[`CT_WIDTH-1:0]; // R2 R15
    end
  end

  // interrupt mask
  always @(posedge clock) begin
    if (!rst_n) begin
      irq_mask_q <= `RST_IRQ;
    end else if (sel_mask) begin
      irq_mask_q <= mask_wr[`IRQ_WIDTH-1:0];
    end
  end

  // store-control word: completion zeroes it, beating a write in flight
  always @(posedge clock) begin
    if (!rst_n) begin
      store_word_q <= `RST_STORE_WORD;
    end else if (store_finish) begin
      store_word_q <= `STORE_IDLE; // R7 R17
    end else if (sel_word) begin
      store_word_q <= word_wr[15:0]; // R15
    end
  end

  // configured record quantity
  always @(posedge clock) begin
    if (!rst_n) begin
      rec_limit_q <= `RST_REC_LIMIT;
    end else if (sel_limit) begin
      rec_limit_q <= limit_wr;
    end
  end

  // record counter, read-only to software
  always @(posedge clock) begin
    if (!rst_n) begin
      rec_count_q <= `RST_REC_COUNT;
    end else if (record_ok) begin
      rec_count_q <= rec_count_q + 32'h0000_0001; // R6
    end
  end

  // card error flag and last code; a good store or card removal clears the flag
  always @(posedge clock) begin
    if (!rst_n) begin
      card_error_q <= 1'b0;
      err_code_q   <= `RST_ERR_CODE;
    end else begin
      if (store_failed) begin
        card_error_q <= 1'b1; // R10
        err_code_q   <= card_fail_code; // R11
      end else if (store_ok | ~card_detect) begin
        card_error_q <= 1'b0; // R10
      end
    end
  end

  // file name stamp taken as the store starts
  always @(posedge clock) begin
    if (!rst_n) begin
      file_stamp_q <= 56'h00_0000_0000_0000;
    end else if (store_go) begin
      file_stamp_q <= {rtc_year, rtc_month, rtc_day,
                       rtc_hour, rtc_minute, rtc_second}; // R14
    end
  end

  // edge history of the store trigger bit
  always @(posedge clock) begin
    if (!rst_n) begin
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= control_q[`CT_STORE_TRIG];
    end
  end

  // edge history of the limit flag
  always @(posedge clock) begin
    if (!rst_n) begin
      limit_prev_q <= 1'b0;
    end else begin
      limit_prev_q <= limit_now;
    end
  end

  // card detect history follows the pin in reset too, so an inserted card
  // gives no false change event as reset lets go
  always @(posedge clock) begin
    if (!rst_n) begin
      card_prev_q <= card_detect;
    end else begin
      card_prev_q <= card_detect;
    end
  end

  // sticky interrupt bits: a new event wins over a write-one clear
  always @(posedge clock) begin
    if (!rst_n) begin
      irq_status_q <= `RST_IRQ;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clr) | irq_events;
    end
  end

endmodule
`default_nettype wire

// [verilog/logger_regs.vh]
// register map, field positions, reset values and codes of the data logger control
`ifndef LOGGER_REGS_VH
`define LOGGER_REGS_VH

// register byte offsets
`define OFF_STATUS      8'h00
`define OFF_CONTROL     8'h04
`define OFF_STORE_WORD  8'h08
`define OFF_ERR_CODE    8'h0C
`define OFF_REC_COUNT   8'h10
`define OFF_REC_LIMIT   8'h14
`define OFF_IRQ_STATUS  8'h18
`define OFF_IRQ_MASK    8'h1C

// status register fields
`define ST_CARD_PRESENT 0
`define ST_STORING      1
`define ST_CARD_ERROR   2
`define ST_LIMIT        3
`define ST_CONFIGURED   4

// control register fields
`define CT_RECORD_RUN   0
`define CT_STORE_TRIG   1
`define CT_CYCLIC       2
`define CT_WIDTH        3

// interrupt status and mask fields
`define IRQ_STORE_DONE  0
`define IRQ_CARD_ERROR  1
`define IRQ_LIMIT       2
`define IRQ_CARD_CHANGE 3
`define IRQ_WIDTH       4

// store-control word codes
`define STORE_KEY       16'h5AA5
`define STORE_IDLE      16'h0000

// reset values
`define RST_CONTROL     3'h0
`define RST_STORE_WORD  16'h0000
`define RST_ERR_CODE    16'h0000
`define RST_REC_COUNT   32'h0000_0000
`define RST_REC_LIMIT   32'h0000_0000
`define RST_IRQ         4'h0

// store sequencer states
`define SQ_IDLE         1'b0
`define SQ_RUN          1'b1

`endif

// [verilog/store_sequencer.v]
// card store sequencer: one store at a time, start pulse out, completion in
`timescale 1ns/1ps
`default_nettype none
`include "logger_regs.vh"

module store_sequencer (
  // clock and reset
  input  wire clock,
  input  wire rst_n,
  // request from register logic
  input  wire go,
  // card side answer
  input  wire card_done,
  input  wire card_fail,
  // status
  output reg  busy_q,
  output reg  start_q,
  output wire finish,
  output wire failed
);

  localparam IDLE = `SQ_IDLE;
  localparam RUN  = `SQ_RUN;

  reg state_q;
  reg state_d;

  // completion is seen the same edge the state drops back to idle
  assign finish = (state_q == RUN) & (card_done | card_fail);
  assign failed = (state_q == RUN) & card_fail;

  always @* begin
    state_d = state_q;
    case (state_q)
      IDLE: begin
        if (go) begin
          state_d = RUN;
        end
      end
      RUN: begin
        if (card_done | card_fail) begin
          state_d = IDLE;
        end
      end
      default: begin
        state_d = IDLE;
      end
    endcase
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      state_q <= IDLE;
      busy_q  <= 1'b0;
      start_q <= 1'b0;
    end else begin
      state_q <= state_d;
      busy_q  <= (state_d == RUN);
      start_q <= (state_q == IDLE) & go;
    end
  end

endmodule
`default_nettype wire

// [testbench/logger_ctrl_asserts.sv]
// port checker for the logger control block
`timescale 1ns/1ps
`default_nettype none
module logger_ctrl_asserts (
  // clock, reset and bus
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // card and stamp
  input wire logic        card_done,
  input wire logic        card_fail,
  input wire logic        card_store_start,
  input wire logic [15:0] rtc_year,
  input wire logic [7:0]  rtc_second,
  input wire logic [55:0] file_stamp_q,
  input wire logic        irq
);
  logic busy_q;
  // tracks one store from launch to the card answer
  always @(posedge clock) begin
    if (!rst_n) busy_q <= 1'b0;
    else if (card_store_start) busy_q <= 1'b1;
    else if (card_done || card_fail) busy_q <= 1'b0;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_pulse;
    card_store_start ##1 !card_store_start;
  endsequence
  AST_ACK_LAT: assert property (s_req |=> ack_o) else $error("ack late");
  AST_ACK_ONE: assert property (ack_o |=> !ack_o) else $error("ack too long");
  AST_START_PULSE: assert property (card_store_start |-> s_pulse) else $error("start long");
  AST_ONE_STORE: assert property (busy_q |-> !card_store_start) else $error("second store");
  AST_STAMP: assert property (card_store_start |-> file_stamp_q[55:40] == $past(rtc_year)
    && file_stamp_q[7:0] == $past(rtc_second)) else $error("stamp wrong");
  AST_STAMP_HOLD: assert property (!card_store_start |-> $stable(file_stamp_q))
    else $error("stamp moved");
  AST_DAT_HOLD: assert property (!ack_o |-> $stable(dat_o)) else $error("read data moved");
  AST_RST: assert property (disable iff (1'b0) !rst_n |=> !ack_o && !card_store_start && !irq)
    else $error("reset state wrong");
endmodule
bind logger_ctrl logger_ctrl_asserts u_chk (.clock, .rst_n, .cyc_i, .stb_i, .dat_o, .ack_o,
  .card_done, .card_fail, .card_store_start, .rtc_year, .rtc_second, .file_stamp_q, .irq);
`default_nettype wire

// [testbench/card_model.sv]
// memory card stand-in: answers a store after a fixed delay, ok or failed
`timescale 1ns/1ps
`default_nettype none
module card_model #(parameter int DLY = 12) (
  // clock and launch
  input  wire logic        clock,
  input  wire logic        card_store_start,
  // bench controls
  input  wire logic        present,
  input  wire logic        fail_mode,
  input  wire logic [15:0] code,
  // card answer
  output logic             card_detect,
  output var logic         card_done = 1'b0,
  output var logic         card_fail = 1'b0,
  output logic [15:0]      card_fail_code
);
  int cnt = 0;
  assign card_detect = present;
  // code means nothing beside a fail pulse, so show its inverse otherwise
  assign card_fail_code = card_fail ? code : ~code;
  always @(posedge clock) begin
    card_done <= 1'b0;
    card_fail <= 1'b0;
    if (card_store_start) cnt <= DLY;
    else if (cnt == 1) begin
      card_done <= !fail_mode;
      card_fail <= fail_mode;
      cnt <= 0;
    end else if (cnt > 1) cnt <= cnt - 1;
  end
endmodule
`default_nettype wire

// [testbench/tb.sv]
// self-checking bench for the logger control block
`timescale 1ns/1ps
`default_nettype none
`include "logger_regs.vh"
module tb;
  logic        clock, rst_n, cyc_i, stb_i, we_i, ack_o, irq, params_valid, record_taken;
  logic        card_detect, card_done, card_fail, card_store_start, present, fail_mode;
  logic [7:0]  adr_i, rtc_month, rtc_day, rtc_hour, rtc_minute, rtc_second;
  logic [3:0]  sel_i;
  logic [15:0] card_fail_code, code, rtc_year, v;
  logic [31:0] dat_i, dat_o, rd_q, lim;
  logic [31:0] rng = 32'h0000_c9dc;
  logic [55:0] file_stamp_q;
  int          bad_count = 0, cmp_count = 0, starts = 0, dones = 0;
  logger_ctrl dut (.clock, .rst_n, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .sel_i, .dat_o,
    .ack_o, .params_valid, .record_taken, .card_detect, .card_done, .card_fail,
    .card_fail_code, .card_store_start, .rtc_year, .rtc_month, .rtc_day, .rtc_hour,
    .rtc_minute, .rtc_second, .file_stamp_q, .irq);
  card_model card (.clock, .card_store_start, .present, .fail_mode, .code, .card_detect,
    .card_done, .card_fail, .card_fail_code);
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    rtc_second <= rtc_second + 8'h01;
    if (card_store_start === 1'b1) starts <= starts + 1;
    if (card_done === 1'b1 || card_fail === 1'b1) dones <= dones + 1;
  end
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle; bounded wait so a dead slave ends the run
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    do begin
      @(posedge clock);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    rd_q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (ack_o !== 1'b1) begin
      bad_count++;
      end_sim();
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk(rd_q, e);
  endtask
  task till(input int a, input int d);
    int n;
    n = 0;
    while ((starts != a || dones != d) && n < 300) begin
      @(posedge clock);
      n++;
    end
    if (n >= 300) begin
      bad_count++;
      end_sim();
    end
  endtask
  initial begin
    {rst_n, cyc_i, stb_i, we_i, adr_i, dat_i, sel_i, record_taken, params_valid} = '0;
    {present, fail_mode, code} = {2'b10, 16'h0000};
    {rtc_year, rtc_month, rtc_day, rtc_hour, rtc_minute, rtc_second} = {xs(), xs()};
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    rd(`OFF_STATUS, 32'h0000_0001);
    params_valid <= 1'b1;
    rd(`OFF_STATUS, 32'h0000_0011);
    wr(`OFF_STATUS, 32'hffff_ffff);
    wr(`OFF_ERR_CODE, 32'h0000_ffff);
    rd(`OFF_STATUS, 32'h0000_0011);
    rd(`OFF_ERR_CODE, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    // bit 8 set keeps the word off both the key and zero
    v = xs() | 16'h0100;
    wr(`OFF_STORE_WORD, {16'h0000, v});
    wr(`OFF_CONTROL, 32'h0000_0002);
    wr(`OFF_CONTROL, 32'h0000_0000);
    chk(starts, 0);
    rd(`OFF_STORE_WORD, {16'h0000, v});
    code <= xs();
    fail_mode <= 1'b1;
    wr(`OFF_IRQ_MASK, 32'h0000_0003);
    wr(`OFF_STORE_WORD, `STORE_KEY);
    wr(`OFF_CONTROL, 32'h0000_0002);
    till(1, 0);
    rd(`OFF_STATUS, 32'h0000_0013);
    till(1, 1);
    rd(`OFF_STATUS, 32'h0000_0015);
    rd(`OFF_STORE_WORD, 32'h0000_0000);
    rd(`OFF_ERR_CODE, {16'h0000, code});
    rd(`OFF_IRQ_STATUS, 32'h0000_0003);
    chk(irq, 1'b1);
    wr(`OFF_IRQ_STATUS, 32'h0000_0003);
    chk(irq, 1'b0);
    fail_mode <= 1'b0;
    lim = 32'h0000_0003 + xs() % 4;
    wr(`OFF_CONTROL, 32'h0000_0000);
    wr(`OFF_STORE_WORD, `STORE_KEY);
    wr(`OFF_REC_LIMIT, lim);
    wr(`OFF_CONTROL, 32'h0000_0001);
    repeat (lim + 2) begin
      @(posedge clock);
      record_taken <= 1'b1;
      @(posedge clock);
      record_taken <= 1'b0;
    end
    till(2, 2);
    rd(`OFF_REC_COUNT, lim);
    rd(`OFF_STATUS, 32'h0000_0019);
    rd(`OFF_CONTROL, 32'h0000_0001);
    rd(`OFF_STORE_WORD, 32'h0000_0000);
    wr(`OFF_REC_COUNT, 32'h0000_0000);
    rd(`OFF_REC_COUNT, lim);
    present <= 1'b0;
    rd(`OFF_STATUS, 32'h0000_0018);
    rd(`OFF_IRQ_STATUS, 32'h0000_000d);
    wr(`OFF_IRQ_MASK, 32'h0000_0008);
    chk(irq, 1'b1);
    wr(`OFF_IRQ_MASK, 32'h0000_0000);
    chk(irq, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
